// ==== rtl/pdc_pkg.sv ====
// Package with constants, types and helpers of the PWM duty current capture block
package pdc_pkg;

  localparam int N_CAP         = 4;        // Capture channels
  localparam int N_PHASE       = 2;        // Current measuring channels
  localparam int CH_ENC1       = 0;        // Encoder channel one
  localparam int CH_ENC2       = 1;        // Encoder channel two
  localparam int CH_PHA        = 2;        // Phase A current channel
  localparam int CH_PHB        = 3;        // Phase B current channel
  localparam int CLK_MHZ       = 125;      // Clock rate
  localparam int CAP_LAT_CYC   = 4;        // Edge to timer latch
  localparam int INT_SYNC_CYC  = 2;        // Internal request sync
  localparam int EXT_SYNC_CYC  = 4;        // External request sync
  localparam int ACK_CYC       = 4;        // Request acknowledge time
  localparam int PREP_CYC      = 6;        // Context save before read
  localparam int MIN_PULSE_NS  = 1870;     // Narrowest carrier pulse
  // Least time, so round up
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int DIV_STEPS     = 16;       // Quotient bits
  localparam int STACK_DEPTH   = 2;        // Capture stack entries

  typedef logic [15:0] pdc_tick_t;         // Timer value
  typedef logic [3:0]  pdc_cnt_t;          // Small wait counter
  typedef logic [1:0]  pdc_lvl_t;          // Stack fill level

  localparam pdc_tick_t TMR_RST   = 16'h0000;  // Timer after reset
  localparam pdc_tick_t DUTY_MID  = 16'h8000;  // Duty of zero current
  localparam pdc_tick_t MIN_PULSE = pdc_tick_t'(MIN_PULSE_CYC);
  localparam pdc_lvl_t  LVL_FULL  = pdc_lvl_t'(STACK_DEPTH);
  localparam pdc_cnt_t  ACK_LOAD  = pdc_cnt_t'(ACK_CYC - 1);
  localparam pdc_cnt_t  PREP_LOAD = pdc_cnt_t'(PREP_CYC - 1);
  localparam logic [4:0] DIV_LOAD = 5'(DIV_STEPS);

  // Service sequence of one phase channel
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACK  = 3'b001,
    ST_PREP = 3'b010,
    ST_READ = 3'b011,
    ST_DIV  = 3'b100
  } pdc_phase_st_t;

  // Width between two stamps, modulo the timer range
  function automatic pdc_tick_t pdc_wrap_diff(input pdc_tick_t late, input pdc_tick_t early);
    pdc_wrap_diff = late - early;
  endfunction : pdc_wrap_diff

endpackage : pdc_pkg

// ==== rtl/pdc_cap_stack.sv ====
// Two entry capture stack holding the newest timer stamps of one channel
`timescale 1ns/1ps
module pdc_cap_stack
  import pdc_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      arst_n,
  input  wire logic      push,
  input  wire pdc_tick_t push_data,
  input  wire logic      pop,
  output pdc_tick_t      older,
  output pdc_tick_t      newer,
  output pdc_lvl_t       level,
  output logic           overflow
);

  typedef struct packed {
    pdc_tick_t older;     // Second newest stamp
    pdc_tick_t newer;     // Newest stamp
    pdc_lvl_t  level;     // Entries held
    logic      overflow;  // Sticky until next pop
  } pdc_stack_state_t;

  pdc_stack_state_t state_r;  // Registered state
  pdc_stack_state_t state_nxt; // Next state

  // Pop empties first, so a push in the same cycle is kept
  always_comb begin
    state_nxt = state_r;
    if (pop) begin
      state_nxt.level    = 2'h0;
      state_nxt.overflow = 1'b0;
    end
    if (push) begin
      state_nxt.older = state_r.newer;
      state_nxt.newer = push_data;
      // Oldest entry is dropped when full; reader sees the flag
      if (state_nxt.level == LVL_FULL) begin
        state_nxt.overflow = 1'b1;
      end else begin
        state_nxt.level = state_nxt.level + 2'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign older    = state_r.older;
  assign newer    = state_r.newer;
  assign level    = state_r.level;
  assign overflow = state_r.overflow;

endmodule : pdc_cap_stack

// ==== rtl/pdc_divider.sv ====
// Restoring divider giving a sixteen bit fraction of dividend over divisor
`timescale 1ns/1ps
module pdc_divider
  import pdc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire pdc_tick_t   dividend,
  input  wire logic [16:0] divisor,
  output pdc_tick_t        quotient,
  output logic             done
);

  typedef struct packed {
    logic        busy;    // Iterating
    logic [4:0]  step;    // Steps left
    logic [16:0] rem;     // Partial remainder
    logic [16:0] dvs;     // Held divisor
    pdc_tick_t   quo;     // Quotient being built
    logic        done;    // One cycle result strobe
  } pdc_div_state_t;

  pdc_div_state_t state_r;   // Registered state
  pdc_div_state_t state_nxt; // Next state

  // One quotient bit per cycle; a zero divisor or equal operands give all ones
  always_comb begin
    logic [17:0] trial;
    trial = '0;
    state_nxt = state_r;
    state_nxt.done = 1'b0;
    if (!state_r.busy) begin
      // Start is ignored while busy
      if (start) begin
        state_nxt.busy = 1'b1;
        state_nxt.step = DIV_LOAD;
        state_nxt.rem  = {1'b0, dividend};
        state_nxt.dvs  = divisor;
        state_nxt.quo  = '0;
      end
    end else begin
      trial = {state_r.rem, 1'b0};
      if (trial >= {1'b0, state_r.dvs}) begin
        state_nxt.rem = 17'(trial - {1'b0, state_r.dvs});
        state_nxt.quo = {state_r.quo[14:0], 1'b1};
      end else begin
        state_nxt.rem = trial[16:0];
        state_nxt.quo = {state_r.quo[14:0], 1'b0};
      end
      state_nxt.step = state_r.step - 5'h01;
      if (state_r.step == 5'h01) begin
        state_nxt.busy = 1'b0;
        state_nxt.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign quotient = state_r.quo;
  assign done     = state_r.done;

endmodule : pdc_divider

// ==== rtl/pdc_top.sv ====
// Top of the PWM duty current capture block: timer, capture, service and duty
`timescale 1ns/1ps
module pdc_top
  import pdc_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   arst_n,
  input  wire logic   encoder_capture_input_1,
  input  wire logic   encoder_capture_input_2,
  input  wire logic   phase_a_capture_input,
  input  wire logic   phase_b_capture_input,
  input  wire logic   encoder_pop_1,
  input  wire logic   encoder_pop_2,
  output logic        encoder_event_1,
  output logic        encoder_event_2,
  output pdc_tick_t   encoder_older_1,
  output pdc_tick_t   encoder_newer_1,
  output pdc_tick_t   encoder_older_2,
  output pdc_tick_t   encoder_newer_2,
  output logic        phase_a_edge_interrupt,
  output logic        phase_b_edge_interrupt,
  output pdc_tick_t   phase_a_on_width,
  output pdc_tick_t   phase_a_off_width,
  output pdc_tick_t   phase_a_duty,
  output pdc_tick_t   phase_a_current,
  output logic        phase_a_valid,
  output logic        phase_a_runt,
  output pdc_tick_t   phase_b_on_width,
  output pdc_tick_t   phase_b_off_width,
  output pdc_tick_t   phase_b_duty,
  output pdc_tick_t   phase_b_current,
  output logic        phase_b_valid,
  output logic        phase_b_runt,
  output logic [3:0]  stack_overflow
);

  // State of timer, capture pipelines and service sequences in one record; stacks and dividers hold their own
  typedef struct packed {
    pdc_tick_t                                timer;     // Free running count
    logic [N_CAP-1:0]                         in_prev;   // Last sampled inputs
    logic [N_CAP-1:0][CAP_LAT_CYC-2:0]        edge_dly;  // Edge to latch delay
    logic [N_CAP-1:0][INT_SYNC_CYC-1:0]       evt_dly;   // Capture event sync
    logic [N_PHASE-1:0][EXT_SYNC_CYC-1:0]     fall_dly;  // External request sync
    pdc_phase_st_t [N_PHASE-1:0]              st;        // Service sequence
    pdc_cnt_t [N_PHASE-1:0]                   cnt;       // Wait counter
    pdc_tick_t [N_PHASE-1:0]                  last_fall; // Previous falling stamp
    pdc_tick_t [N_PHASE-1:0]                  on_w;      // High width
    pdc_tick_t [N_PHASE-1:0]                  off_w;     // Low width
    pdc_tick_t [N_PHASE-1:0]                  duty;      // High over period
    pdc_tick_t [N_PHASE-1:0]                  current;   // Signed current value
    logic [N_PHASE-1:0]                       have_fall; // Previous fall known
    logic [N_PHASE-1:0]                       irq;       // Interrupt pulse
    logic [N_PHASE-1:0]                       valid;     // Result strobe
    logic [N_PHASE-1:0]                       runt;      // Pulse below minimum
  } pdc_top_state_t;

  pdc_top_state_t state_r;    // Registered state
  pdc_top_state_t state_nxt;  // Next state

  logic [N_CAP-1:0]               cap_in;     // Channel inputs by index
  logic [N_CAP-1:0]               cap_push;   // Stamp push strobes
  logic [N_CAP-1:0]               cap_pop;    // Stack read strobes
  pdc_tick_t [N_CAP-1:0]          stk_older;  // Second newest stamps
  pdc_tick_t [N_CAP-1:0]          stk_newer;  // Newest stamps
  pdc_lvl_t [N_CAP-1:0]           stk_level;  // Stack fill
  logic [N_PHASE-1:0]             div_start;  // Divider launch
  pdc_tick_t [N_PHASE-1:0]        div_quo;    // Divider fraction
  logic [N_PHASE-1:0]             div_done;   // Divider strobe
  pdc_tick_t [N_PHASE-1:0]        rd_on;      // High width from stack
  pdc_tick_t [N_PHASE-1:0]        rd_off;     // Low width from stack
  logic [N_PHASE-1:0][16:0]       rd_sum;     // Carrier period

  assign cap_in[CH_ENC1] = encoder_capture_input_1;
  assign cap_in[CH_ENC2] = encoder_capture_input_2;
  // carrier taken straight from the pin
  assign cap_in[CH_PHA]  = phase_a_capture_input;
  assign cap_in[CH_PHB]  = phase_b_capture_input;

  // push at the end of the latency line
  assign cap_push = {state_r.edge_dly[3][CAP_LAT_CYC-2], state_r.edge_dly[2][CAP_LAT_CYC-2],
                     state_r.edge_dly[1][CAP_LAT_CYC-2], state_r.edge_dly[0][CAP_LAT_CYC-2]};

  // Encoder stacks are drained by their user, phase stacks by the service sequence
  assign cap_pop[CH_ENC1] = encoder_pop_1;
  assign cap_pop[CH_ENC2] = encoder_pop_2;
  assign cap_pop[CH_PHA]  = (state_r.st[0] == ST_READ);
  assign cap_pop[CH_PHB]  = (state_r.st[1] == ST_READ);

  for (genvar c = 0; c < N_CAP; c++) begin : g_stack
    pdc_cap_stack u_stack (
      .clock     (clock),
      .arst_n    (arst_n),
      .push      (cap_push[c]),
      .push_data (state_r.timer),
      .pop       (cap_pop[c]),
      .older     (stk_older[c]),
      .newer     (stk_newer[c]),
      .level     (stk_level[c]),
      .overflow  (stack_overflow[c])
    );
  end

  // Width arithmetic and divider per phase channel
  for (genvar p = 0; p < N_PHASE; p++) begin : g_phase
    // newest minus older is the high width
    // modulo timer range across a wrap
    assign rd_on[p]  = pdc_wrap_diff(stk_newer[CH_PHA+p], stk_older[CH_PHA+p]);
    // low width from previous fall to this rise
    assign rd_off[p] = pdc_wrap_diff(stk_older[CH_PHA+p], state_r.last_fall[p]);
    assign rd_sum[p] = {1'b0, rd_on[p]} + {1'b0, rd_off[p]};
    // A period with a lost rising stamp is not measured
    assign div_start[p] = (state_r.st[p] == ST_READ) && (stk_level[CH_PHA+p] == LVL_FULL)
                          && state_r.have_fall[p];

    // duty as high width over period
    // Fed from the stack read itself, so duty belongs to the same period as the widths
    pdc_divider u_div (
      .clock    (clock),
      .arst_n   (arst_n),
      .start    (div_start[p]),
      .dividend (rd_on[p]),
      .divisor  (rd_sum[p]),
      .quotient (div_quo[p]),
      .done     (div_done[p])
    );
  end

  // Next state of timer, capture pipelines and the two service sequences
  always_comb begin
    logic [N_CAP-1:0] edge_now;
    logic [N_CAP-1:0] fall_now;
    edge_now  = '0;
    fall_now  = '0;
    state_nxt = state_r;

    // sixteen bit free running timer, wraps naturally
    state_nxt.timer   = state_r.timer + 16'h0001;
    state_nxt.in_prev = cap_in;

    for (int c = 0; c < N_CAP; c++) begin
      // any level change is a capture edge
      edge_now[c] = cap_in[c] ^ state_r.in_prev[c];
      fall_now[c] = state_r.in_prev[c] & ~cap_in[c];
      // delay line sets the latch moment
      state_nxt.edge_dly[c] = {state_r.edge_dly[c][CAP_LAT_CYC-3:0], edge_now[c]};
      // every capture passes the internal sync; only the encoder channels raise an event from it
      state_nxt.evt_dly[c] = {state_r.evt_dly[c][INT_SYNC_CYC-2:0], cap_push[c]};
    end

    for (int p = 0; p < N_PHASE; p++) begin
      state_nxt.irq[p]   = 1'b0;
      state_nxt.valid[p] = 1'b0;
      // only the falling edge requests service
      state_nxt.fall_dly[p] = {state_r.fall_dly[p][EXT_SYNC_CYC-2:0], fall_now[CH_PHA+p]};

      case (state_r.st[p])
        // Waiting for a synchronised falling edge
        ST_IDLE: begin
          if (state_r.fall_dly[p][EXT_SYNC_CYC-1]) begin
            state_nxt.irq[p] = 1'b1;
            state_nxt.st[p]  = ST_ACK;
            state_nxt.cnt[p] = ACK_LOAD;
          end
        end
        ST_ACK: begin
          if (state_r.cnt[p] == 4'h0) begin
            state_nxt.st[p]  = ST_PREP;
            state_nxt.cnt[p] = PREP_LOAD;
          end else begin
            state_nxt.cnt[p] = state_r.cnt[p] - 4'h1;
          end
        end
        // context save before the stack read
        ST_PREP: begin
          if (state_r.cnt[p] == 4'h0) begin
            state_nxt.st[p] = ST_READ;
          end else begin
            state_nxt.cnt[p] = state_r.cnt[p] - 4'h1;
          end
        end
        // read both entries in one cycle
        ST_READ: begin
          if (stk_level[CH_PHA+p] == LVL_FULL) begin
            state_nxt.on_w[p]      = rd_on[p];
            state_nxt.off_w[p]     = rd_off[p];
            state_nxt.last_fall[p] = stk_newer[CH_PHA+p];
            state_nxt.have_fall[p] = 1'b1;
            state_nxt.st[p]        = div_start[p] ? ST_DIV : ST_IDLE;
          end else begin
            // Missing stamps: restart the low width reference
            state_nxt.have_fall[p] = 1'b0;
            state_nxt.st[p]        = ST_IDLE;
          end
        end
        // duty to signed current around the midpoint
        ST_DIV: begin
          if (div_done[p]) begin
            state_nxt.duty[p]    = div_quo[p];
            state_nxt.current[p] = div_quo[p] - DUTY_MID;
            state_nxt.valid[p]   = 1'b1;
            // flag pulses narrower than the least width
            state_nxt.runt[p]    = (state_r.on_w[p] < MIN_PULSE) ||
                                   (state_r.off_w[p] < MIN_PULSE);
            state_nxt.st[p]      = ST_IDLE;
          end
        end
        default: begin
          state_nxt.st[p] = ST_IDLE;
        end
      endcase
    end
  end

  // State register; timer starts from its reset value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r       <= '0;
      state_r.timer <= TMR_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state record and, for encoder stamps and overflow flags, the capture stacks
  assign encoder_event_1        = state_r.evt_dly[CH_ENC1][INT_SYNC_CYC-1];
  assign encoder_event_2        = state_r.evt_dly[CH_ENC2][INT_SYNC_CYC-1];
  assign encoder_older_1        = stk_older[CH_ENC1];
  assign encoder_newer_1        = stk_newer[CH_ENC1];
  assign encoder_older_2        = stk_older[CH_ENC2];
  assign encoder_newer_2        = stk_newer[CH_ENC2];
  assign phase_a_edge_interrupt = state_r.irq[0];
  assign phase_b_edge_interrupt = state_r.irq[1];
  assign phase_a_on_width       = state_r.on_w[0];
  assign phase_a_off_width      = state_r.off_w[0];
  assign phase_a_duty           = state_r.duty[0];
  assign phase_a_current        = state_r.current[0];
  assign phase_a_valid          = state_r.valid[0];
  assign phase_a_runt           = state_r.runt[0];
  assign phase_b_on_width       = state_r.on_w[1];
  assign phase_b_off_width      = state_r.off_w[1];
  assign phase_b_duty           = state_r.duty[1];
  assign phase_b_current        = state_r.current[1];
  assign phase_b_valid          = state_r.valid[1];
  assign phase_b_runt           = state_r.runt[1];

endmodule : pdc_top

// ==== dv/pdc_carrier_model.sv ====
// Behavioural PWM carrier source standing in for the current sensing chip
`timescale 1ns/1ps
module pdc_carrier_model
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [15:0] high_cyc,  // Carrier high time in cycles
  input  wire logic [15:0] low_cyc,   // Carrier low time in cycles
  output logic             carrier    // Carrier pin towards the block
);
  int count_r;  // Cycles spent at the present level

  // carrier with set duty
  // Moves on the falling edge so the block always samples a settled level
  always @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      carrier <= 1'b0;
      count_r <= 1;
    end else if (count_r >= int'(carrier ? high_cyc : low_cyc)) begin
      carrier <= ~carrier;
      count_r <= 1;
    end else begin
      count_r <= count_r + 1;
    end
  end
endmodule : pdc_carrier_model

// ==== dv/pdc_monitor.sv ====
// Checker of the PWM duty current capture block, bound to its top
`timescale 1ns/1ps
module pdc_monitor
  import pdc_pkg::*;
(
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       encoder_capture_input_1,
  input wire logic       encoder_capture_input_2,
  input wire logic       phase_a_capture_input,
  input wire logic       phase_b_capture_input,
  input wire logic       encoder_pop_1,
  input wire logic       encoder_event_1,
  input wire logic       encoder_event_2,
  input wire logic       phase_a_edge_interrupt,
  input wire logic       phase_b_edge_interrupt,
  input wire pdc_tick_t  phase_a_duty,
  input wire pdc_tick_t  phase_a_current,
  input wire pdc_tick_t  phase_a_on_width,
  input wire pdc_tick_t  phase_a_off_width,
  input wire logic       phase_a_valid,
  input wire logic       phase_a_runt,
  input wire logic       phase_b_valid,
  input wire logic [3:0] stack_overflow
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic       prev_a_r, prev_b_r;  // Last sampled carrier levels
  logic [5:0] fall_a_r, fall_b_r;  // Cycles since a carrier fall
  logic [5:0] irq_a_r, irq_b_r;    // Cycles since an interrupt

  // Saturating step, so a long quiet spell never wraps to a small count
  function automatic logic [5:0] sat(input logic [5:0] v);
    sat = (v == 6'h3F) ? v : v + 6'h01;
  endfunction : sat

  // Counters start saturated so an output without a cause fails at once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_a_r <= 1'b0;
      prev_b_r <= 1'b0;
      fall_a_r <= 6'h3F;
      fall_b_r <= 6'h3F;
      irq_a_r  <= 6'h3F;
      irq_b_r  <= 6'h3F;
    end else begin
      prev_a_r <= phase_a_capture_input;
      prev_b_r <= phase_b_capture_input;
      fall_a_r <= (prev_a_r && !phase_a_capture_input) ? 6'h00 : sat(fall_a_r);
      fall_b_r <= (prev_b_r && !phase_b_capture_input) ? 6'h00 : sat(fall_b_r);
      irq_a_r  <= phase_a_edge_interrupt ? 6'h00 : sat(irq_a_r);
      irq_b_r  <= phase_b_edge_interrupt ? 6'h00 : sat(irq_b_r);
    end
  end

  sequence s_enc_edge_1; $changed(encoder_capture_input_1); endsequence
  sequence s_enc_edge_2; $changed(encoder_capture_input_2); endsequence
  sequence s_service_a; phase_a_edge_interrupt ##[20:36] phase_a_valid; endsequence

  a_irq_follows_fall: assert property (phase_a_edge_interrupt |-> fall_a_r inside {[2:7]})
    else $error("phase A interrupt without a recent carrier fall");
  a_irq_b_follows: assert property (phase_b_edge_interrupt |-> fall_b_r inside {[2:7]})
    else $error("phase B interrupt without a recent carrier fall");
  a_irq_single_shot: assert property (phase_a_edge_interrupt |=> !phase_a_edge_interrupt [*8])
    else $error("phase A interrupt repeated");
  a_valid_after_irq: assert property (phase_a_valid |-> irq_a_r inside {[22:34]})
    else $error("phase A result outside the service window");
  a_valid_b_after: assert property (phase_b_valid |-> irq_b_r inside {[22:34]})
    else $error("phase B result outside the service window");
  a_current_offset: assert property (phase_a_valid |=> phase_a_current == phase_a_duty - DUTY_MID)
    else $error("phase A current not duty minus midpoint");
  a_runt_flag_set: assert property (phase_a_valid |=> phase_a_runt ==
      (phase_a_on_width < MIN_PULSE || phase_a_off_width < MIN_PULSE))
    else $error("phase A narrow pulse flag wrong");
  a_enc_capture_1: assert property (s_enc_edge_1 |-> ##[4:8] encoder_event_1)
    else $error("encoder one edge not captured");
  a_enc_capture_2: assert property (s_enc_edge_2 |-> ##[4:8] encoder_event_2)
    else $error("encoder two edge not captured");
  a_pop_clears_flag: assert property (encoder_pop_1 |=> !stack_overflow[0])
    else $error("encoder one overflow not cleared by pop");
  c_service_a: cover property (s_service_a);
endmodule : pdc_monitor

bind pdc_top pdc_monitor pdc_monitor_inst (
  .clock, .arst_n, .encoder_capture_input_1, .encoder_capture_input_2,
  .phase_a_capture_input, .phase_b_capture_input, .encoder_pop_1,
  .encoder_event_1, .encoder_event_2, .phase_a_edge_interrupt, .phase_b_edge_interrupt,
  .phase_a_duty, .phase_a_current, .phase_a_on_width, .phase_a_off_width,
  .phase_a_valid, .phase_a_runt, .phase_b_valid, .stack_overflow
);

// ==== dv/pwm_duty_current_capture_test.sv ====
// Self-checking testbench of the PWM duty current capture block
`timescale 1ns/1ps
`define PDC_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module pwm_duty_current_capture_test
  import pdc_pkg::*;
;
  logic        clock;          // Bench clock
  logic        arst_n;         // Bench reset
  logic [1:0]  enc_in;         // Encoder pins
  logic [1:0]  enc_pop;        // Encoder stack pops
  logic [15:0] hi_cyc [2];     // Carrier high times
  logic [15:0] lo_cyc [2];     // Carrier low times
  logic [1:0]  carrier;        // Carrier pins from the models
  logic [1:0]  enc_ev, irq, valid, runt;
  pdc_tick_t   older [2];
  pdc_tick_t   newer [2];
  pdc_tick_t   on_w [2];
  pdc_tick_t   off_w [2];
  pdc_tick_t   duty [2];
  pdc_tick_t   cur [2];
  logic [3:0]  ovf;            // Stack overflow flags
  int          mismatches, checked;
  int          ev_cnt [2];     // Encoder events seen

  always #4 clock = ~clock;

  // Count encoder events for the capture checks; sampled where the pulse is settled
  always @(negedge clock) begin
    if (enc_ev[0] === 1'b1) ev_cnt[0]++;
    if (enc_ev[1] === 1'b1) ev_cnt[1]++;
  end

  for (genvar g = 0; g < 2; g++) begin : g_car
    pdc_carrier_model pdc_carrier_model_inst (.clock(clock), .arst_n(arst_n),
      .high_cyc(hi_cyc[g]), .low_cyc(lo_cyc[g]), .carrier(carrier[g]));
  end

  pdc_top pdc_top_inst (
    .clock(clock), .arst_n(arst_n),
    .encoder_capture_input_1(enc_in[0]), .encoder_capture_input_2(enc_in[1]),
    .phase_a_capture_input(carrier[0]), .phase_b_capture_input(carrier[1]),
    .encoder_pop_1(enc_pop[0]), .encoder_pop_2(enc_pop[1]),
    .encoder_event_1(enc_ev[0]), .encoder_event_2(enc_ev[1]),
    .encoder_older_1(older[0]), .encoder_newer_1(newer[0]),
    .encoder_older_2(older[1]), .encoder_newer_2(newer[1]),
    .phase_a_edge_interrupt(irq[0]), .phase_b_edge_interrupt(irq[1]),
    .phase_a_on_width(on_w[0]), .phase_a_off_width(off_w[0]),
    .phase_a_duty(duty[0]), .phase_a_current(cur[0]),
    .phase_a_valid(valid[0]), .phase_a_runt(runt[0]),
    .phase_b_on_width(on_w[1]), .phase_b_off_width(off_w[1]),
    .phase_b_duty(duty[1]), .phase_b_current(cur[1]),
    .phase_b_valid(valid[1]), .phase_b_runt(runt[1]),
    .stack_overflow(ovf)
  );

  // Prints the counts and the verdict, then ends the run
  task automatic conclude;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Bounded wait for a result pulse, then move to a quiet edge
  task automatic wait_valid(input int ph);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (valid[ph] !== 1'b1 && n < 8000);
    if (valid[ph] !== 1'b1) begin
      mismatches++;
      conclude();
    end
    @(negedge clock);
  endtask : wait_valid

  // Overflow flags and phase A duty idle after reset
  task automatic reset_check;
    repeat (2) @(negedge clock);
    `PDC_CHK(ovf, 4'h0)
    `PDC_CHK(duty[0], 16'h0000)
  endtask : reset_check

  // Sets a carrier, skips the mixed period, then checks reps results
  task automatic phase_check(input int ph, input logic [15:0] hi, input logic [15:0] lo,
                             input int reps);
    logic [32:0] q;
    pdc_tick_t   exp_duty;
    hi_cyc[ph] <= hi;
    lo_cyc[ph] <= lo;
    wait_valid(ph);
    repeat (reps) begin
      wait_valid(ph);
      q = {hi, 16'h0000} / (33'(hi) + 33'(lo));
      exp_duty = (q > 33'h0FFFF) ? 16'hFFFF : q[15:0];
      `PDC_CHK(on_w[ph], hi)
      `PDC_CHK(off_w[ph], lo)
      `PDC_CHK(duty[ph], exp_duty)
      `PDC_CHK(cur[ph], exp_duty - DUTY_MID)
      `PDC_CHK(runt[ph], (hi < MIN_PULSE) || (lo < MIN_PULSE))
      `PDC_CHK(ovf[ph + 2], 1'b0)
    end
  endtask : phase_check

  // Three edges gap apart into an empty stack, then a pop
  task automatic enc_check(input int ch, input int gap);
    int base;
    base = ev_cnt[ch];
    repeat (3) begin
      @(negedge clock);
      enc_in[ch] <= ~enc_in[ch];
      repeat (gap - 1) @(negedge clock);
    end
    repeat (12) @(negedge clock);
    `PDC_CHK(pdc_tick_t'(newer[ch] - older[ch]), pdc_tick_t'(gap))
    `PDC_CHK(ev_cnt[ch] - base, 3)
    `PDC_CHK(ovf[ch], 1'b1)
    enc_pop[ch] <= 1'b1;
    @(negedge clock);
    enc_pop[ch] <= 1'b0;
    @(negedge clock);
    `PDC_CHK(ovf[ch], 1'b0)
  endtask : enc_check

  // Main sequence; the long phase B run carries the timer through a wrap
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    enc_in = 2'b00;
    enc_pop = 2'b00;
    hi_cyc[0] = 16'h012C;
    lo_cyc[0] = 16'h0B09;
    hi_cyc[1] = 16'h05DC;
    lo_cyc[1] = 16'h0659;
    mismatches = 0;
    checked = 0;
    ev_cnt[0] = 0;
    ev_cnt[1] = 0;
    repeat (20) @(negedge clock);
    arst_n <= 1'b1;
    reset_check();
    enc_check(0, 1);
    enc_check(1, 57);
    phase_check(0, 16'h012C, 16'h0B09, 1);
    phase_check(0, 16'h00C8, 16'h0B6D, 1);
    phase_check(0, 16'h0BB8, 16'h007D, 1);
    phase_check(1, 16'h05DC, 16'h0659, 16);
    conclude();
  end
endmodule : pwm_duty_current_capture_test
